/* inc/rps_pkg.sv */
// Constants for the protocol-select and framing register bank.
// Assumes a single 20 MHz system clock.
`default_nettype none
package rps_pkg;
  localparam logic [4:0] ADDR_CHIP  = 5'h00;
  localparam logic [4:0] ADDR_PROTO = 5'h01;
  localparam logic [4:0] ADDR_TYPEB = 5'h02;
  localparam logic [4:0] ADDR_TYPEA = 5'h03;
  localparam logic [4:0] ADDR_LL_LO = 5'h04;
  localparam logic [4:0] ADDR_LL_HI = 5'h0B;
  localparam int LL_N = 8;
  localparam int CHIP_DIRECT_BIT = 6;
  localparam int PROTO_NOCRC_BIT = 7;
  localparam int PROTO_DTYPE_BIT = 6;
  localparam int TB_EGT_MSB = 7;
  localparam int TB_EGT_LSB = 5;
  localparam int TB_EOF_BIT = 4;
  localparam int TB_SOFH_BIT = 3;
  localparam int TB_SOFL_BIT = 2;
  localparam int TB_EGT_EACH_BIT = 1;
  localparam int TA_DIFF_BIT = 7;
  localparam int TA_TXBR_MSB = 6;
  localparam int TA_TXBR_LSB = 5;
  localparam logic [7:0] CHIP_RST  = 8'h01;
  localparam logic [7:0] PROTO_RST = 8'h02;
  localparam logic [7:0] TYPEB_RST = 8'h00;
  localparam logic [7:0] TYPEA_RST = 8'h00;
  localparam logic [7:0] LL_RST [LL_N] = '{8'hC2, 8'h00, 8'h00, 8'h0E,
                                          8'h00, 8'h00, 8'h00, 8'h00};
  localparam int LL_KEEP_IDX = 5;
  localparam logic [7:0] LL_KEEP_MASK = 8'h30;
  localparam logic [4:0] CODE_VIC_LAST = 5'h07;
  localparam logic [4:0] CODE_A_FIRST  = 5'h08;
  localparam logic [4:0] CODE_B_FIRST  = 5'h0C;
  localparam logic [4:0] CODE_B_LAST   = 5'h0F;
  localparam logic [4:0] CODE_LEGACY   = 5'h13;
  localparam logic [3:0] EOF_LONG  = 4'hB;
  localparam logic [3:0] EOF_SHORT = 4'hA;
  localparam logic [3:0] SOFL_LONG  = 4'hB;
  localparam logic [3:0] SOFL_SHORT = 4'hA;
  localparam logic [3:0] SOFH_LONG  = 4'h3;
  localparam logic [3:0] SOFH_SHORT = 4'h2;
  localparam logic [3:0] CHAR_ETU   = 4'hA;
  localparam int SYNC_LEN = 3;
  typedef enum logic [1:0] {RATE_106, RATE_212, RATE_424, RATE_848} rps_rate_t;
  typedef enum logic [2:0] {FAM_VIC_SINGLE, FAM_VIC_DOUBLE, FAM_PROX_A,
                            FAM_PROX_B, FAM_LEGACY, FAM_RESERVED} rps_family_t;
  typedef enum logic [2:0] {FB_IDLE, FB_SOF_LO, FB_SOF_HI, FB_CHAR,
                            FB_EGT, FB_EOF} rps_phase_t;
endpackage : rps_pkg
`default_nettype wire

/* hdl/rps_proto_decode.sv */
// Decodes the five-bit protocol code into family, rates and coding.
// Assumes both inputs come from registers on the system clock.
`default_nettype none
module rps_proto_decode (
  input  wire logic [4:0]          i_code,
  input  wire logic [7:0]          i_typea,
  output rps_pkg::rps_family_t     o_family,
  output logic                     o_vic_fast,
  output logic                     o_coding_256,
  output rps_pkg::rps_rate_t       o_rx_rate,
  output rps_pkg::rps_rate_t       o_tx_rate,
  output logic                     o_reserved
);
  import rps_pkg::*;

  always_comb begin
    o_family     = FAM_RESERVED;
    o_vic_fast   = 1'b0;
    o_coding_256 = 1'b0;
    o_rx_rate    = RATE_106;
    if (i_code <= CODE_VIC_LAST) begin
      o_family     = i_code[2] ? FAM_VIC_DOUBLE : FAM_VIC_SINGLE;
      o_vic_fast   = i_code[1];
      o_coding_256 = i_code[0];
    end else if (i_code < CODE_B_FIRST) begin
      o_family  = FAM_PROX_A;
      o_rx_rate = rps_rate_t'(i_code[1:0]);
    end else if (i_code <= CODE_B_LAST) begin
      o_family  = FAM_PROX_B;
      o_rx_rate = rps_rate_t'(i_code[1:0]);
    end else if (i_code == CODE_LEGACY) begin
      o_family = FAM_LEGACY;
    end
    o_reserved = (o_family == FAM_RESERVED);
  end

  // A separate transmit rate applies only to the fast proximity codes.
  always_comb begin
    o_tx_rate = o_rx_rate;
    if ((o_family == FAM_PROX_A || o_family == FAM_PROX_B) &&
        o_rx_rate != RATE_106 && i_typea[TA_DIFF_BIT]) begin
      o_tx_rate = rps_rate_t'(i_typea[TA_TXBR_MSB:TA_TXBR_LSB]);
    end
  end
endmodule : rps_proto_decode
`default_nettype wire

/* hdl/rps_typeb_framer.sv */
// Sequences one type B transmit frame in elementary time units.
// Assumes i_etu_tick is a one-cycle pulse per etu on the system clock.
`default_nettype none
module rps_typeb_framer (
  input  wire logic                i_clk_sys,
  input  wire logic                i_rst,
  input  wire logic                i_ce,
  input  wire logic [7:0]          i_opts,
  input  wire logic                i_start,
  input  wire logic                i_etu_tick,
  input  wire logic                i_last_byte,
  output rps_pkg::rps_phase_t      o_phase,
  output logic                     o_done
);
  import rps_pkg::*;

  rps_phase_t  st_r, st_nxt;
  logic [3:0]  cnt_r, cnt_nxt;
  logic [7:0]  opt_r, opt_nxt;
  logic        last_r, last_nxt;
  logic        done_nxt;
  logic [3:0]  egt;
  logic        fin;

  assign egt = {1'b0, opt_r[TB_EGT_MSB:TB_EGT_LSB]};
  assign fin = i_etu_tick && cnt_r == 4'h1;

  always_comb begin
    st_nxt   = st_r;
    cnt_nxt  = (i_etu_tick && cnt_r != 4'h0) ? cnt_r - 4'h1 : cnt_r;
    opt_nxt  = opt_r;
    last_nxt = last_r;
    done_nxt = 1'b0;
    case (st_r)
      FB_IDLE: begin
        if (i_start) begin
          opt_nxt = i_opts;
          st_nxt  = FB_SOF_LO;
          cnt_nxt = i_opts[TB_SOFL_BIT] ? SOFL_LONG : SOFL_SHORT;
        end
      end
      FB_SOF_LO: begin
        if (fin) begin
          st_nxt  = FB_SOF_HI;
          cnt_nxt = opt_r[TB_SOFH_BIT] ? SOFH_LONG : SOFH_SHORT;
        end
      end
      FB_SOF_HI: begin
        if (fin) begin
          st_nxt  = FB_CHAR;
          cnt_nxt = CHAR_ETU;
        end
      end
      FB_CHAR: begin
        if (fin) begin
          last_nxt = i_last_byte;
          if (egt != 4'h0 && (!i_last_byte || opt_r[TB_EGT_EACH_BIT])) begin
            st_nxt  = FB_EGT;
            cnt_nxt = egt;
          end else if (i_last_byte) begin
            st_nxt  = FB_EOF;
            cnt_nxt = opt_r[TB_EOF_BIT] ? EOF_LONG : EOF_SHORT;
          end else begin
            cnt_nxt = CHAR_ETU;
          end
        end
      end
      FB_EGT: begin
        if (fin) begin
          st_nxt  = last_r ? FB_EOF : FB_CHAR;
          cnt_nxt = last_r ? (opt_r[TB_EOF_BIT] ? EOF_LONG : EOF_SHORT) : CHAR_ETU;
        end
      end
      FB_EOF: begin
        if (fin) begin
          st_nxt   = FB_IDLE;
          done_nxt = 1'b1;
        end
      end
      default: st_nxt = FB_IDLE;
    endcase
  end

  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      st_r   <= FB_IDLE;
      cnt_r  <= 4'h0;
      opt_r  <= TYPEB_RST;
      last_r <= 1'b0;
      o_done <= 1'b0;
    end else if (i_ce) begin
      st_r   <= st_nxt;
      cnt_r  <= cnt_nxt;
      opt_r  <= opt_nxt;
      last_r <= last_nxt;
      o_done <= done_nxt;
    end
  end

  assign o_phase = st_r;

  property p_egt_len;
    @(posedge i_clk_sys) disable iff (i_rst)
    (i_ce && st_r == FB_CHAR && st_nxt == FB_EGT) |=> (cnt_r == egt);
  endproperty
  a_egt_len: assert property (p_egt_len) else $error("Guard length wrong.");

  property p_last_egt;
    @(posedge i_clk_sys) disable iff (i_rst)
    (i_ce && st_r == FB_CHAR && fin && i_last_byte && !opt_r[TB_EGT_EACH_BIT])
      |=> (st_r == FB_EOF);
  endproperty
  a_last_egt: assert property (p_last_egt) else $error("Guard after last.");
endmodule : rps_typeb_framer
`default_nettype wire

/* hdl/rps_top.sv */
// Protocol-select and type B framing register bank of the reader.
// Assumes the host port decoder delivers one-cycle read and write
// strobes with address and data, and a stop pulse, on the system clock.
`default_nettype none
module rps_top (
  input  wire logic                i_clk_sys,
  input  wire logic                i_rst,
  input  wire logic                i_ce,
  input  wire logic                i_en_pin,
  input  wire logic                i_wr,
  input  wire logic                i_rd,
  input  wire logic [4:0]          i_addr,
  input  wire logic [7:0]          i_wdata,
  output logic [7:0]               o_rdata,
  input  wire logic                i_stop,
  input  wire logic                i_dec_bit,
  input  wire logic                i_dec_clk,
  input  wire logic                i_subcarrier,
  output logic                     o_dir_data,
  output logic                     o_dir_clk,
  output logic                     o_direct_active,
  output logic                     o_rx_crc_check,
  output rps_pkg::rps_family_t     o_family,
  output logic                     o_vic_fast,
  output logic                     o_coding_256,
  output rps_pkg::rps_rate_t       o_rx_rate,
  output rps_pkg::rps_rate_t       o_tx_rate,
  output logic                     o_proto_reserved,
  output logic [8*rps_pkg::LL_N-1:0] o_ll_cfg,
  input  wire logic                i_tx_start,
  input  wire logic                i_etu_tick,
  input  wire logic                i_last_byte,
  output rps_pkg::rps_phase_t      o_tx_phase,
  output logic                     o_tx_done
);
  import rps_pkg::*;

  logic [SYNC_LEN-1:0] en_sync_r;
  logic                en_lvl_r, en_lvl_nxt;
  logic [7:0]          chip_r, chip_nxt;
  logic [7:0]          proto_r, proto_nxt;
  logic [7:0]          typeb_r, typeb_nxt;
  logic [7:0]          typea_r, typea_nxt;
  logic [7:0]          ll_r [LL_N];
  logic [7:0]          rdata_nxt;
  logic                dir_data_nxt, dir_clk_nxt;
  logic                wr_chip, wr_proto, wr_typeb, wr_typea;
  logic                defaults;
  logic                tx_go;

  // The chip-activate pin is asynchronous; a level counts once the
  // second and third stages agree.
  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      en_sync_r <= '0;
      en_lvl_r  <= 1'b0;
    end else if (i_ce) begin
      en_sync_r <= {en_sync_r[SYNC_LEN-2:0], i_en_pin};
      en_lvl_r  <= en_lvl_nxt;
    end
  end

  always_comb begin
    en_lvl_nxt = en_lvl_r;
    if (en_sync_r[1] == en_sync_r[2]) begin
      en_lvl_nxt = en_sync_r[2];
    end
  end

  assign defaults = !en_lvl_r;
  assign wr_chip  = i_wr && i_addr == ADDR_CHIP;
  assign wr_proto = i_wr && i_addr == ADDR_PROTO;
  assign wr_typeb = i_wr && i_addr == ADDR_TYPEB;
  assign wr_typea = i_wr && i_addr == ADDR_TYPEA;

  // Main registers. Bit 5 of the protocol register is stored as
  // written; the host is expected to keep it zero.
  always_comb begin
    chip_nxt  = chip_r;
    proto_nxt = proto_r;
    typeb_nxt = typeb_r;
    typea_nxt = typea_r;
    if (defaults) begin
      chip_nxt  = CHIP_RST;
      proto_nxt = PROTO_RST;
      typeb_nxt = TYPEB_RST;
      typea_nxt = TYPEA_RST;
    end else begin
      if (wr_chip) begin
        chip_nxt = i_wdata;
      end
      if (i_stop) begin
        chip_nxt[CHIP_DIRECT_BIT] = 1'b0;
      end
      if (wr_proto) begin
        proto_nxt = i_wdata;
        typea_nxt = TYPEA_RST;
      end else if (wr_typea) begin
        typea_nxt = i_wdata;
      end
      if (wr_typeb) begin
        typeb_nxt = i_wdata;
      end
    end
  end

  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      chip_r  <= CHIP_RST;
      proto_r <= PROTO_RST;
      typeb_r <= TYPEB_RST;
      typea_r <= TYPEA_RST;
    end else if (i_ce) begin
      chip_r  <= chip_nxt;
      proto_r <= proto_nxt;
      typeb_r <= typeb_nxt;
      typea_r <= typea_nxt;
    end
  end

  // Low-level option registers; a protocol write reloads them except
  // the clock-output bits, which survive protocol changes.
  genvar g;
  generate
    for (g = 0; g < LL_N; g++) begin : g_ll
      logic [7:0] ll_nxt;
      localparam logic [7:0] KEEP = (g == LL_KEEP_IDX) ? LL_KEEP_MASK : 8'h00;
      always_comb begin
        ll_nxt = ll_r[g];
        if (defaults) begin
          ll_nxt = LL_RST[g];
        end else if (wr_proto) begin
          ll_nxt = (LL_RST[g] & ~KEEP) | (ll_r[g] & KEEP);
        end else if (i_wr && i_addr == ADDR_LL_LO + 5'(g)) begin
          ll_nxt = i_wdata;
        end
      end
      always_ff @(posedge i_clk_sys or posedge i_rst) begin
        if (i_rst) begin
          ll_r[g] <= LL_RST[g];
        end else if (i_ce) begin
          ll_r[g] <= ll_nxt;
        end
      end
      assign o_ll_cfg[8*g +: 8] = ll_r[g];
    end
  endgenerate

  // Read port: unmapped addresses read as zero.
  always_comb begin
    rdata_nxt = o_rdata;
    if (i_rd) begin
      if (i_addr == ADDR_CHIP) begin
        rdata_nxt = chip_r;
      end else if (i_addr == ADDR_PROTO) begin
        rdata_nxt = proto_r;
      end else if (i_addr == ADDR_TYPEB) begin
        rdata_nxt = typeb_r;
      end else if (i_addr == ADDR_TYPEA) begin
        rdata_nxt = typea_r;
      end else if (i_addr >= ADDR_LL_LO && i_addr <= ADDR_LL_HI) begin
        rdata_nxt = ll_r[3'(i_addr - ADDR_LL_LO)];
      end else begin
        rdata_nxt = 8'h00;
      end
    end
  end

  assign o_direct_active = chip_r[CHIP_DIRECT_BIT];
  assign o_rx_crc_check  = !proto_r[PROTO_NOCRC_BIT];

  // Direct-mode pin drive.
  always_comb begin
    dir_data_nxt = 1'b0;
    dir_clk_nxt  = 1'b0;
    if (o_direct_active) begin
      if (proto_r[PROTO_DTYPE_BIT]) begin
        dir_data_nxt = i_dec_bit;
        dir_clk_nxt  = i_dec_clk;
      end else begin
        dir_data_nxt = i_subcarrier;
      end
    end
  end

  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      o_rdata    <= 8'h00;
      o_dir_data <= 1'b0;
      o_dir_clk  <= 1'b0;
    end else if (i_ce) begin
      o_rdata    <= rdata_nxt;
      o_dir_data <= dir_data_nxt;
      o_dir_clk  <= dir_clk_nxt;
    end
  end

  rps_proto_decode u_decode (
    .i_code       (proto_r[4:0]),
    .i_typea      (typea_r),
    .o_family     (o_family),
    .o_vic_fast   (o_vic_fast),
    .o_coding_256 (o_coding_256),
    .o_rx_rate    (o_rx_rate),
    .o_tx_rate    (o_tx_rate),
    .o_reserved   (o_proto_reserved)
  );

  assign tx_go = i_tx_start && o_family == FAM_PROX_B;

  rps_typeb_framer u_framer (
    .i_clk_sys   (i_clk_sys),
    .i_rst       (i_rst),
    .i_ce        (i_ce),
    .i_opts      (typeb_r),
    .i_start     (tx_go),
    .i_etu_tick  (i_etu_tick),
    .i_last_byte (i_last_byte),
    .o_phase     (o_tx_phase),
    .o_done      (o_tx_done)
  );

  default clocking cb @(posedge i_clk_sys); endclocking
  default disable iff (i_rst);

  property p_crc_off;
    (i_ce && !defaults && wr_proto && i_wdata[PROTO_NOCRC_BIT]) |=> !o_rx_crc_check;
  endproperty
  a_crc_off: assert property (p_crc_off) else $error("CRC not disabled.");

  property p_dir_dec;
    (i_ce && o_direct_active && proto_r[PROTO_DTYPE_BIT]) |=>
      (o_dir_data == $past(i_dec_bit) && o_dir_clk == $past(i_dec_clk));
  endproperty
  a_dir_dec: assert property (p_dir_dec) else $error("Direct bit stream wrong.");

  property p_proto_dflt;
    (i_ce && defaults) |=> (proto_r == PROTO_RST && o_family == FAM_VIC_SINGLE
                            && o_vic_fast && !o_coding_256);
  endproperty
  a_proto_dflt: assert property (p_proto_dflt) else $error("Bad default protocol.");

  property p_typeb_code;
    (proto_r[4:0] == CODE_B_FIRST) |-> (o_family == FAM_PROX_B && o_rx_rate == RATE_106);
  endproperty
  a_typeb_code: assert property (p_typeb_code) else $error("Type B decode wrong.");

  property p_tb_only;
    (o_tx_phase == FB_IDLE && o_family != FAM_PROX_B) |=> (o_tx_phase == FB_IDLE);
  endproperty
  a_tb_only: assert property (p_tb_only) else $error("Framer ran outside type B.");

  property p_typeb_rst;
    (i_ce && defaults) |=> (typeb_r == TYPEB_RST);
  endproperty
  a_typeb_rst: assert property (p_typeb_rst) else $error("Type B options not reset.");

  property p_typea_clr;
    (i_ce && wr_proto) |=> (typea_r == TYPEA_RST);
  endproperty
  a_typea_clr: assert property (p_typea_clr) else $error("Type A options kept.");

  property p_ll_reload;
    (i_ce && !defaults && wr_proto) |=> (ll_r[0] == LL_RST[0] && ll_r[3] == LL_RST[3]);
  endproperty
  a_ll_reload: assert property (p_ll_reload) else $error("Options not reloaded.");

  property p_stop_ends;
    (i_ce && i_stop) |=> !o_direct_active;
  endproperty
  a_stop_ends: assert property (p_stop_ends) else $error("Stop kept direct mode.");
endmodule : rps_top
`default_nettype wire

/* verification/rps_host_model.sv */
// Host microcontroller model that drives the register port of the bank.
// Assumes the bank samples strobes on the rising edge of i_clk_sys.
`default_nettype none
module rps_host_model (
  input  wire logic       i_clk_sys,
  input  wire logic [7:0] i_rdata,
  output logic            o_wr,
  output logic            o_rd,
  output logic [4:0]      o_addr,
  output logic [7:0]      o_wdata,
  output logic            o_stop
);
  timeunit 1ns;
  timeprecision 1ns;
  import rps_pkg::*;

  initial begin
    o_wr    = 1'b0;
    o_rd    = 1'b0;
    o_addr  = 5'h1F;
    o_wdata = 8'hA5;
    o_stop  = 1'b0;
  end

  task automatic write_reg(input logic [4:0] addr, input logic [7:0] data);
    @(posedge i_clk_sys);
    o_wr    <= 1'b1;
    o_addr  <= addr;
    o_wdata <= (addr == ADDR_PROTO) ? (data & 8'hDF) : data;
    @(posedge i_clk_sys);
    o_wr    <= 1'b0;
    o_wdata <= ~data;
    #1;
  endtask : write_reg

  task automatic read_reg(input logic [4:0] addr, output logic [7:0] data);
    @(posedge i_clk_sys);
    o_rd   <= 1'b1;
    o_addr <= addr;
    @(posedge i_clk_sys);
    o_rd   <= 1'b0;
    #1;
    data = i_rdata;
  endtask : read_reg

  task automatic send_stop;
    @(posedge i_clk_sys);
    o_stop <= 1'b1;
    @(posedge i_clk_sys);
    o_stop <= 1'b0;
    #1;
  endtask : send_stop
endmodule : rps_host_model
`default_nettype wire

/* verification/rps_tb.sv */
// Self-checking bench for the protocol-select and framing bank.
// Assumes the host model drives the register port; the bench drives the rest.
`default_nettype none
module rfid_protocol_select_framing_test;
  timeunit 1ns;
  timeprecision 1ns;
  import rps_pkg::*;

  logic                clk;
  logic                rst;
  logic                en;
  logic                wr;
  logic                rd;
  logic [4:0]          addr;
  logic [7:0]          wdata;
  logic [7:0]          rdata;
  logic                stop;
  logic                dbit;
  logic                dclk;
  logic                sub;
  logic                dir_data;
  logic                dir_clk;
  logic                dir_act;
  logic                crc_chk;
  rps_family_t         fam;
  logic                vfast;
  logic                c256;
  rps_rate_t           rxr;
  rps_rate_t           txr;
  logic                resv;
  logic [8*LL_N-1:0]   ll;
  logic                start;
  logic                etu;
  logic                last;
  rps_phase_t          phase;
  logic                done;
  int                  fail_count;
  int                  checks;
  int                  cycles;
  int                  done_cnt;

  rps_host_model host (.i_clk_sys(clk), .i_rdata(rdata), .o_wr(wr), .o_rd(rd),
                       .o_addr(addr), .o_wdata(wdata), .o_stop(stop));

  rps_top dut (.i_clk_sys(clk), .i_rst(rst), .i_ce(1'b1), .i_en_pin(en), .i_wr(wr),
               .i_rd(rd), .i_addr(addr), .i_wdata(wdata), .o_rdata(rdata),
               .i_stop(stop), .i_dec_bit(dbit), .i_dec_clk(dclk), .i_subcarrier(sub),
               .o_dir_data(dir_data), .o_dir_clk(dir_clk), .o_direct_active(dir_act),
               .o_rx_crc_check(crc_chk), .o_family(fam), .o_vic_fast(vfast),
               .o_coding_256(c256), .o_rx_rate(rxr), .o_tx_rate(txr),
               .o_proto_reserved(resv), .o_ll_cfg(ll), .i_tx_start(start),
               .i_etu_tick(etu), .i_last_byte(last), .o_tx_phase(phase), .o_tx_done(done));

  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (done === 1'b1) done_cnt <= done_cnt + 1;
    if (cycles == 20000) begin
      fail_count++;
      conclude();
    end
  end

  task automatic conclude;
    $display("checks %0d mismatches %0d", checks, fail_count);
    if (fail_count == 0 && checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : conclude

  task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
    checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
    end
  endtask : check

  task automatic rd_chk(input logic [4:0] a, input logic [7:0] exp);
    logic [7:0] v;
    host.read_reg(a, v);
    check("rdata", v, exp);
  endtask : rd_chk

  task automatic test_defaults;
    rd_chk(ADDR_PROTO, 8'h02);
    rd_chk(ADDR_TYPEB, 8'h00);
    rd_chk(ADDR_TYPEA, 8'h00);
    rd_chk(5'h10, 8'h00);
    check("crc", 8'(crc_chk), 8'h01);
    check("family", 8'(fam), 8'(FAM_VIC_SINGLE));
    check("fast", 8'(vfast), 8'h01);
    check("coding", 8'(c256), 8'h00);
    $display("test_defaults done");
  endtask : test_defaults

  task automatic test_codes;
    logic [4:0] c;
    for (int i = 0; i < 16; i++) begin
      c = 5'(i);
      host.write_reg(ADDR_PROTO, {3'b000, c});
      check("reserved", 8'(resv), 8'h00);
      if (i < 8) begin
        check("family", 8'(fam), (i < 4) ? 8'(FAM_VIC_SINGLE) : 8'(FAM_VIC_DOUBLE));
        check("fast", 8'(vfast), 8'(c[1]));
        check("coding", 8'(c256), 8'(c[0]));
      end else begin
        check("family", 8'(fam), (i < 12) ? 8'(FAM_PROX_A) : 8'(FAM_PROX_B));
        check("rx_rate", 8'(rxr), 8'(c[1:0]));
      end
    end
    host.write_reg(ADDR_PROTO, 8'h10);
    check("reserved", 8'(resv), 8'h01);
    host.write_reg(ADDR_PROTO, 8'h13);
    check("family", 8'(fam), 8'(FAM_LEGACY));
    check("reserved", 8'(resv), 8'h00);
    $display("test_codes done");
  endtask : test_codes

  task automatic test_rates_reload;
    host.write_reg(ADDR_PROTO, 8'h09);
    host.write_reg(ADDR_TYPEA, 8'hE0);
    check("rx_rate", 8'(rxr), 8'(RATE_212));
    check("tx_rate", 8'(txr), 8'(RATE_848));
    host.write_reg(ADDR_TYPEA, 8'h60);
    check("tx_rate", 8'(txr), 8'(RATE_212));
    host.write_reg(ADDR_LL_LO, 8'h55);
    host.write_reg(5'h09, 8'hFF);
    host.write_reg(ADDR_TYPEA, 8'hE0);
    host.write_reg(ADDR_PROTO, 8'h8C);
    rd_chk(ADDR_TYPEA, 8'h00);
    rd_chk(ADDR_LL_LO, 8'hC2);
    rd_chk(5'h09, 8'h30);
    check("ll_cfg", ll[7:0], 8'hC2);
    check("crc", 8'(crc_chk), 8'h00);
    rd_chk(ADDR_PROTO, 8'h8C);
    $display("test_rates_reload done");
  endtask : test_rates_reload

  task automatic test_en_pin;
    host.write_reg(ADDR_TYPEB, 8'h5E);
    host.write_reg(ADDR_PROTO, 8'h0D);
    @(posedge clk);
    en <= 1'b0;
    repeat (8) @(posedge clk);
    en <= 1'b1;
    repeat (8) @(posedge clk);
    rd_chk(ADDR_TYPEB, 8'h00);
    rd_chk(ADDR_PROTO, 8'h02);
    $display("test_en_pin done");
  endtask : test_en_pin

  task automatic test_direct;
    host.write_reg(ADDR_PROTO, 8'h02);
    host.write_reg(ADDR_CHIP, 8'h41);
    check("direct", 8'(dir_act), 8'h01);
    @(posedge clk);
    sub  <= 1'b0;
    dbit <= 1'b1;
    dclk <= 1'b1;
    repeat (3) @(posedge clk);
    #1;
    check("dir_data", 8'(dir_data), 8'h00);
    check("dir_clk", 8'(dir_clk), 8'h00);
    host.write_reg(ADDR_PROTO, 8'h42);
    repeat (3) @(posedge clk);
    #1;
    check("dir_data", 8'(dir_data), 8'h01);
    check("dir_clk", 8'(dir_clk), 8'h01);
    host.send_stop();
    check("direct", 8'(dir_act), 8'h00);
    $display("test_direct done");
  endtask : test_direct

  // Counts etu ticks until the framer leaves the given phase.
  task automatic run_phase(input rps_phase_t ph, input int n);
    int k;
    k = 0;
    check("phase", 8'(phase), 8'(ph));
    while (phase === ph && k < 16) begin
      @(posedge clk);
      etu <= 1'b1;
      @(posedge clk);
      etu <= 1'b0;
      @(posedge clk);
      #1;
      k++;
    end
    check("etu_count", 8'(k), 8'(n));
  endtask : run_phase

  task automatic pulse_start;
    @(posedge clk);
    start <= 1'b1;
    @(posedge clk);
    start <= 1'b0;
    @(posedge clk);
    #1;
  endtask : pulse_start

  task automatic test_framer(input logic [7:0] opts, input logic each, input int lo,
                             input int hi, input int eofn);
    int d0;
    host.write_reg(ADDR_PROTO, 8'h02);
    pulse_start();
    check("phase", 8'(phase), 8'(FB_IDLE));
    host.write_reg(ADDR_PROTO, 8'h0C);
    host.write_reg(ADDR_TYPEB, opts);
    d0 = done_cnt;
    @(posedge clk);
    last <= 1'b0;
    pulse_start();
    run_phase(FB_SOF_LO, lo);
    run_phase(FB_SOF_HI, hi);
    run_phase(FB_CHAR, 10);
    run_phase(FB_EGT, 2);
    @(posedge clk);
    last <= 1'b1;
    #1;
    run_phase(FB_CHAR, 10);
    if (each) run_phase(FB_EGT, 2);
    run_phase(FB_EOF, eofn);
    check("phase", 8'(phase), 8'(FB_IDLE));
    check("done", 8'(done_cnt - d0), 8'h01);
    $display("test_framer done");
  endtask : test_framer

  initial begin
    fail_count = 0;
    checks     = 0;
    rst        = 1'b1;
    en         = 1'b1;
    dbit       = 1'b0;
    dclk       = 1'b0;
    sub        = 1'b1;
    start      = 1'b0;
    etu        = 1'b0;
    last       = 1'b0;
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    repeat (8) @(posedge clk);
    test_defaults();
    test_codes();
    test_rates_reload();
    test_en_pin();
    test_direct();
    test_framer(8'h5E, 1'b1, 11, 3, 11);
    test_framer(8'h40, 1'b0, 10, 2, 10);
    conclude();
  end
endmodule : rfid_protocol_select_framing_test
`default_nettype wire
